// ---- src/rdc_consts.svh ----
/*
  constants of the remote contact command block: timing, register
  offsets, control field positions and reset values.
  assumes a 100 MHz system clock and a 32-bit wishbone register bus.
*/
`ifndef RDC_CONSTS_SVH
`define RDC_CONSTS_SVH

// timing
`define RDC_CLK_MHZ 100
`define RDC_PULSE_MS 500
`define RDC_PULSE_CYC (`RDC_PULSE_MS * 1000 * `RDC_CLK_MHZ)
`define RDC_DEB_US 1000
`define RDC_DEB_CYC (`RDC_DEB_US * `RDC_CLK_MHZ)
`define RDC_CNT_W 26

// register byte offsets
`define RDC_ADR_CTRL 8'h00
`define RDC_ADR_CMD 8'h04
`define RDC_ADR_STAT 8'h08
`define RDC_ADR_SETP 8'h0c
`define RDC_ADR_SPD0 8'h10
`define RDC_ADR_SPDL 8'h28
`define RDC_SPD_N 7

// control register field positions
`define RDC_C_REMOTE 0
`define RDC_C_PULSE 1
`define RDC_C_REV_EN 2
`define RDC_C_SRC_DI 3
`define RDC_C_SW_EN 4
`define RDC_C_SCHEME7 5
`define RDC_C_PANEL_RUN 6
`define RDC_C_MV_ON 7

// command register field, reset values, speed schemes
`define RDC_CMD_RESET 0
`define RDC_CTRL_RST 8'h00
`define RDC_SCHEME3_MAX 3'h3

`endif

// ---- src/rdc_pkg.sv ----
/*
  types of the remote contact command block.
  assumes rdc_consts.svh is included by the design file.
*/
package rdc_pkg;

  // debounced or raw remote contacts, one bit each except the three-bit speed code sel
  typedef struct packed {
    logic fwd;
    logic rev;
    logic release_in;
    logic [2:0] sel;
    logic mode_sw;
    logic ext_reset;
    logic ext_fault1;
  } rdc_contacts_t;

  // commands handed to the drive
  typedef struct packed {
    logic run_fwd;
    logic run_rev;
    logic out_release;
    logic main_on_a;
    logic main_on_b;
    logic contactor_open;
    logic estop;
    logic fault_reset;
    logic remote;
  } rdc_cmd_t;

  typedef logic signed [15:0] rdc_sp_t;

endpackage

// ---- src/rdc_remote_cmd.sv ----
/*
  remote contact command logic: turns remote terminal strip contacts
  into run, release, setpoint, mode and fault commands for the drive.
  assumes contacts arrive synchronous-enough to be resynchronised here,
  and a classic wishbone master for configuration.
*/
// How it works
// [RULE_01] start/stop contacts act only in remote mode
// [RULE_02] one setting picks level or pulse signalling
// [RULE_03] level: forward contact runs forward if setpoint positive
// [RULE_04] level: forward plus reverse starts reverse; release stops
// [RULE_05] pulse: forward held 500 ms starts by sign
// [RULE_06] level: reverse contact starts reverse after forward
// [RULE_07] level: reverse contact released stops reverse always
// [RULE_08] pulse: reverse held 500 ms stops motor
// [RULE_09] output released only while release contact closed
// [RULE_10] main switch-on outputs ignore release contact
// [RULE_11] setpoint from three coded contacts, 3 or 7 sections
// [RULE_12] switch-over contact picks remote or panel mode
// [RULE_13] reset contact pulse clears faults like panel button
// [RULE_14] external fault 1 acts as emergency stop
// [RULE_15] external fault opens main contactor, else nothing; here ext_fault1 also raises estop
// [RULE_16] plant keeps release contact closed while running
// [RULE_17] every contact synchronised and debounced first
`timescale 1ns/100ps
`include "rdc_consts.svh"

module rdc_remote_cmd
  import rdc_pkg::*;
#(
  parameter logic [`RDC_CNT_W-1:0] DEB_CYC = `RDC_CNT_W'(`RDC_DEB_CYC),
  parameter logic [`RDC_CNT_W-1:0] PULSE_CYC =
    `RDC_CNT_W'(`RDC_PULSE_CYC)
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // remote terminal strip contacts
  input wire rdc_contacts_t contact_input,
  // cabinet emergency stop button
  input wire logic estop_button,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // drive commands
  output rdc_cmd_t drive_cmd,
  output rdc_sp_t setpoint
);

  logic [8:0] db;
  rdc_contacts_t d;
  logic [7:0] ctrl;
  rdc_sp_t psp;
  rdc_sp_t spd [`RDC_SPD_N];
  logic fwd_d, rev_d, rst_d;
  logic [`RDC_CNT_W-1:0] fwd_cnt, rev_cnt;
  logic remote, pos, neg, fwd_fire, rev_fire;
  logic wr, spd_hit, reset_wr;
  logic [2:0] widx, code;
  logic [31:0] next_dat;
  rdc_sp_t next_sp;

  // per contact: two-stage sync, then stable-time debounce
  for (genvar i = 0; i < 9; i++) begin : g_deb
    logic s1, s2;
    logic [`RDC_CNT_W-1:0] cnt;
    always_ff @(posedge clk) begin
      if (rst) begin
        s1 <= 1'b0;
        s2 <= 1'b0;
        cnt <= '0;
        db[i] <= 1'b0;
      end else begin
        s1 <= contact_input[i];
        s2 <= s1; // see [RULE_17]
        if (s2 == db[i]) begin
          cnt <= '0;
        end else if (cnt == DEB_CYC - 1'b1) begin
          db[i] <= s2; // see [RULE_17]
          cnt <= '0;
        end else begin
          cnt <= cnt + 1'b1;
        end
      end
    end
  end

  assign d = rdc_contacts_t'(db);

  // operating mode and setpoint sign
  assign remote = ctrl[`RDC_C_SW_EN] ? d.mode_sw // see [RULE_12]
                                     : ctrl[`RDC_C_REMOTE];
  assign pos = (setpoint > 16'sh0000);
  assign neg = setpoint[15];

  // previous contact levels for edges
  always_ff @(posedge clk) begin
    if (rst) begin
      fwd_d <= 1'b0;
      rev_d <= 1'b0;
      rst_d <= 1'b0;
    end else begin
      fwd_d <= d.fwd;
      rev_d <= d.rev;
      rst_d <= d.ext_reset;
    end
  end

  // hold-time counters for pulse signalling, saturating
  always_ff @(posedge clk) begin
    if (rst) begin
      fwd_cnt <= '0;
      rev_cnt <= '0;
    end else begin
      if (!d.fwd)
        fwd_cnt <= '0;
      else if (fwd_cnt != PULSE_CYC)
        fwd_cnt <= fwd_cnt + 1'b1;
      if (!d.rev)
        rev_cnt <= '0;
      else if (rev_cnt != PULSE_CYC)
        rev_cnt <= rev_cnt + 1'b1;
    end
  end

  // one-shot when a contact has been held the full pulse time
  assign fwd_fire = d.fwd && (fwd_cnt == PULSE_CYC - 1'b1); // see [RULE_05]
  assign rev_fire = d.rev && (rev_cnt == PULSE_CYC - 1'b1); // see [RULE_08]

  // run state: release gate, local, level or pulse handling
  always_ff @(posedge clk) begin
    if (rst) begin
      drive_cmd.run_fwd <= 1'b0;
      drive_cmd.run_rev <= 1'b0;
    end else if (!d.release_in) begin
      drive_cmd.run_fwd <= 1'b0; // see [RULE_09]
      drive_cmd.run_rev <= 1'b0;
    end else if (!remote) begin
      // panel control; contacts ignored, see [RULE_01]
      drive_cmd.run_fwd <= ctrl[`RDC_C_PANEL_RUN] && pos;
      drive_cmd.run_rev <= ctrl[`RDC_C_PANEL_RUN] && neg &&
                           ctrl[`RDC_C_REV_EN];
    end else if (!ctrl[`RDC_C_PULSE]) begin // see [RULE_02]
      drive_cmd.run_fwd <= d.fwd && pos; // see [RULE_03] [RULE_04]
      if (!d.rev)
        drive_cmd.run_rev <= 1'b0; // see [RULE_07]
      else if ((d.rev && !rev_d && d.fwd) || (d.fwd && !fwd_d))
        drive_cmd.run_rev <= neg && ctrl[`RDC_C_REV_EN]; // see [RULE_06]
    end else if (rev_fire) begin
      drive_cmd.run_fwd <= 1'b0; // see [RULE_08]
      drive_cmd.run_rev <= 1'b0;
    end else if (fwd_fire) begin
      drive_cmd.run_fwd <= pos; // see [RULE_05]
      drive_cmd.run_rev <= neg && ctrl[`RDC_C_REV_EN];
    end
  end

  // release, main switch, fault and mode outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      drive_cmd.out_release <= 1'b0;
      drive_cmd.main_on_a <= 1'b0;
      drive_cmd.main_on_b <= 1'b0;
      drive_cmd.contactor_open <= 1'b0;
      drive_cmd.estop <= 1'b0;
      drive_cmd.fault_reset <= 1'b0;
      drive_cmd.remote <= 1'b0;
    end else begin
      drive_cmd.out_release <= d.release_in; // see [RULE_09]
      drive_cmd.main_on_a <= ctrl[`RDC_C_MV_ON]; // see [RULE_10]
      drive_cmd.main_on_b <= ctrl[`RDC_C_MV_ON];
      drive_cmd.contactor_open <= d.ext_fault1; // see [RULE_15]
      drive_cmd.estop <= d.ext_fault1 || estop_button; // see [RULE_14]
      drive_cmd.fault_reset <= (d.ext_reset && !rst_d) || // see [RULE_13]
                               reset_wr;
      drive_cmd.remote <= remote;
    end
  end

  // setpoint from coded contacts or from the panel register
  always_comb begin
    code = d.sel;
    if (!ctrl[`RDC_C_SCHEME7] && code > `RDC_SCHEME3_MAX)
      code = `RDC_SCHEME3_MAX; // see [RULE_11]
    if (!ctrl[`RDC_C_SRC_DI])
      next_sp = psp;
    else if (code == 3'h0)
      next_sp = 16'sh0000;
    else
      next_sp = spd[3'(code - 3'h1)]; // see [RULE_11]
  end

  always_ff @(posedge clk) begin
    if (rst)
      setpoint <= 16'sh0000;
    else
      setpoint <= next_sp;
  end

  // bus decode; a write lands on the edge that sees ack high
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  assign spd_hit = (wb_adr_i >= `RDC_ADR_SPD0) &&
                   (wb_adr_i <= `RDC_ADR_SPDL) && (wb_adr_i[1:0] == 2'h0);
  assign widx = 3'((wb_adr_i - `RDC_ADR_SPD0) >> 2);
  assign reset_wr = wr && (wb_adr_i == `RDC_ADR_CMD) && wb_sel_i[0] &&
                    wb_dat_i[`RDC_CMD_RESET];

  // control and panel setpoint registers
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl <= `RDC_CTRL_RST;
      psp <= 16'sh0000;
    end else if (wr) begin
      if (wb_adr_i == `RDC_ADR_CTRL && wb_sel_i[0])
        ctrl <= wb_dat_i[7:0];
      if (wb_adr_i == `RDC_ADR_SETP) begin
        if (wb_sel_i[0])
          psp[7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1])
          psp[15:8] <= wb_dat_i[15:8];
      end
    end
  end

  // speed section table, one entry per section
  for (genvar j = 0; j < `RDC_SPD_N; j++) begin : g_spd
    always_ff @(posedge clk) begin
      if (rst) begin
        spd[j] <= 16'sh0000;
      end else if (wr && spd_hit && widx == 3'(j)) begin
        if (wb_sel_i[0])
          spd[j][7:0] <= wb_dat_i[7:0];
        if (wb_sel_i[1])
          spd[j][15:8] <= wb_dat_i[15:8];
      end
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    next_dat = 32'h0000_0000;
    case (wb_adr_i)
      `RDC_ADR_CTRL: next_dat = {24'h00_0000, ctrl};
      `RDC_ADR_STAT: next_dat = {setpoint, 2'h0, drive_cmd.remote,
                                 drive_cmd.run_rev, drive_cmd.run_fwd,
                                 drive_cmd.out_release, drive_cmd.estop,
                                 db};
      `RDC_ADR_SETP: next_dat = {16'h0000, psp};
      default: begin
        if (spd_hit)
          next_dat = {16'h0000, spd[widx]};
      end
    endcase
  end

  // one ack per request, one cycle after it is seen
  always_ff @(posedge clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      if (wb_cyc_i && wb_stb_i && !wb_ack_o)
        wb_dat_o <= next_dat;
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_reset_push;
    d.ext_reset && !rst_d;
  endsequence

  sequence s_level_remote;
    remote && !ctrl[`RDC_C_PULSE] && d.release_in;
  endsequence

  chk_local_ignore: assert property ( // see [RULE_01]
    (!remote && !ctrl[`RDC_C_PANEL_RUN]) |=>
      !drive_cmd.run_fwd && !drive_cmd.run_rev)
    else $error("contacts acted in local mode");

  chk_level_fwd: assert property ( // see [RULE_03]
    (s_level_remote and (d.fwd && pos)) |=> drive_cmd.run_fwd)
    else $error("forward level did not start");

  chk_fwd_drop: assert property ( // see [RULE_04]
    (s_level_remote and !d.fwd) |=> !drive_cmd.run_fwd)
    else $error("forward kept after contact release");

  chk_rev_cause: assert property ( // see [RULE_06]
    ($rose(drive_cmd.run_rev) && $past(remote) &&
     !$past(ctrl[`RDC_C_PULSE])) |->
      $past(neg && d.fwd && d.rev && ctrl[`RDC_C_REV_EN]))
    else $error("reverse started without its conditions");

  chk_rev_drop: assert property ( // see [RULE_07]
    (remote && !ctrl[`RDC_C_PULSE] && !d.rev) |=> !drive_cmd.run_rev)
    else $error("reverse kept after contact release");

  chk_pulse_start: assert property ( // see [RULE_05]
    (remote && ctrl[`RDC_C_PULSE] && d.release_in && fwd_fire &&
     !rev_fire && pos) |=> drive_cmd.run_fwd)
    else $error("held forward pulse did not start");

  chk_pulse_stop: assert property ( // see [RULE_08]
    (remote && ctrl[`RDC_C_PULSE] && rev_fire) |=>
      !drive_cmd.run_fwd && !drive_cmd.run_rev)
    else $error("held reverse pulse did not stop");

  chk_short_pulse: assert property ( // see [RULE_08]
    (remote && ctrl[`RDC_C_PULSE] && d.release_in && !fwd_fire &&
     rev_cnt != PULSE_CYC - 1'b1 && drive_cmd.run_fwd) |=>
      drive_cmd.run_fwd)
    else $error("short reverse pulse stopped motor");

  chk_release_gate: assert property ( // see [RULE_09]
    !d.release_in |=> !drive_cmd.run_fwd && !drive_cmd.run_rev &&
                      !drive_cmd.out_release)
    else $error("output not blocked without release");

  chk_main_on: assert property ( // see [RULE_10]
    ctrl[`RDC_C_MV_ON] |=> drive_cmd.main_on_a && drive_cmd.main_on_b)
    else $error("main switch-on dropped");

  chk_sel_zero: assert property ( // see [RULE_11]
    (ctrl[`RDC_C_SRC_DI] && d.sel == 3'h0) |=> setpoint == 16'sh0000)
    else $error("code zero gave nonzero setpoint");

  chk_mode_sw: assert property ( // see [RULE_12]
    ctrl[`RDC_C_SW_EN] |=> drive_cmd.remote == $past(d.mode_sw))
    else $error("switch-over contact ignored");

  chk_ext_reset: assert property ( // see [RULE_13]
    s_reset_push |=> drive_cmd.fault_reset ##1 !drive_cmd.fault_reset)
    else $error("reset contact gave no single pulse");

  chk_ext_fault: assert property ( // see [RULE_14] [RULE_15]
    d.ext_fault1 |=> drive_cmd.contactor_open && drive_cmd.estop)
    else $error("external fault did not trip");

endmodule

// ---- verif/rdc_plant_ctl.sv ----
/*
  plant control side: potential-free contacts towards the drive.
  assumes the bench names the wanted contact levels each cycle.
*/
`timescale 1ns/100ps

module rdc_plant_ctl
  import rdc_pkg::*;
(
  // clock
  input wire logic clk,
  // wanted and driven contacts
  input wire rdc_contacts_t want,
  output rdc_contacts_t contacts
);
  // contacts move just after an edge; release kept closed as told
  always @(posedge clk) begin
    contacts <= want;
  end
endmodule

// ---- verif/tb_top.sv ----
/*
  bench for the remote contact command block: bus tasks, contact
  scenarios and expected values.
  assumes the plant model drives the contacts and small timing counts.
*/
`timescale 1ns/100ps
`include "rdc_consts.svh"

module tb_top
  import rdc_pkg::*;
;
  logic clk, rst, estop_button;
  logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  rdc_contacts_t want, contacts, c;
  rdc_cmd_t drive_cmd;
  rdc_sp_t setpoint;
  int fails, checks, resets, r0;

  rdc_plant_ctl rdc_plant_ctl_inst (.clk(clk), .want(want),
    .contacts(contacts));

  rdc_remote_cmd #(.DEB_CYC(26'h4), .PULSE_CYC(26'h14)) rdc_remote_cmd_inst (
    .clk(clk), .rst(rst), .contact_input(contacts),
    .estop_button(estop_button), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .drive_cmd(drive_cmd), .setpoint(setpoint));

  // clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // count reset pulses handed to the drive
  always @(posedge clk) begin
    if (drive_cmd.fault_reset === 1'b1) resets++;
  end

  task automatic chk(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic hold(input int n);
    repeat (n) @(negedge clk);
  endtask

  // one classic cycle; held until ack is sampled at a rising edge
  task automatic wb(input logic we, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= 4'hf;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    chk("wb_ack_o", 32'h1, {31'h0, wb_ack_o});
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    // idle cycle between requests
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk("read data", exp, q);
  endtask

  // hand the plant new contact levels and let them settle
  task automatic put(input int n);
    @(posedge clk);
    want <= c;
    hold(n);
  endtask

  task automatic blip(input logic rv, input int n);
    rdc_contacts_t k;
    k = c;
    if (rv) k.rev = 1'b1;
    else k.fwd = 1'b1;
    @(posedge clk);
    want <= k;
    hold(n);
    put(30);
  endtask

  task automatic finish_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // watchdog
  initial begin
    #200000;
    fails++;
    finish_test();
  end

  // main sequence
  initial begin
    rst = 1'b1;
    estop_button = 1'b0;
    want = '0;
    c = '0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hf;
    wb_dat_i = 32'h0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(`RDC_ADR_CTRL, 32'h0);
    wr(8'h30, 32'hffffffff);
    rd(8'h30, 32'h0);
    wr(`RDC_ADR_SPD0, 32'h0064);
    wr(8'h14, 32'hffce);
    wr(8'h18, 32'h00c8);
    wr(`RDC_ADR_SPDL, 32'h01f4);
    $display("test registers done");
    // local mode, then switch-over to remote
    c.release_in = 1'b1;
    c.sel = 3'h1;
    c.fwd = 1'b1;
    wr(`RDC_ADR_CTRL, 32'h88);
    put(20);
    chk("run_fwd", 32'h0, drive_cmd.run_fwd);
    chk("setpoint", 32'h0064, setpoint);
    wr(`RDC_ADR_CTRL, 32'h98);
    c.mode_sw = 1'b1;
    put(20);
    chk("remote", 32'h1, drive_cmd.remote);
    chk("run_fwd", 32'h1, drive_cmd.run_fwd);
    c.release_in = 1'b0;
    put(20);
    chk("run_fwd", 32'h0, drive_cmd.run_fwd);
    chk("out_release", 32'h0, drive_cmd.out_release);
    chk("main_on_a", 32'h1, drive_cmd.main_on_a);
    chk("main_on_b", 32'h1, drive_cmd.main_on_b);
    c.release_in = 1'b1;
    put(20);
    chk("out_release", 32'h1, drive_cmd.out_release);
    c.fwd = 1'b0;
    put(20);
    chk("run_fwd", 32'h0, drive_cmd.run_fwd);
    $display("test local and release done");
    // level reverse, negative setpoint
    c.mode_sw = 1'b0;
    c.sel = 3'h2;
    wr(`RDC_ADR_CTRL, 32'h8d);
    c.fwd = 1'b1;
    put(20);
    chk("run_fwd", 32'h0, drive_cmd.run_fwd);
    c.rev = 1'b1;
    put(20);
    chk("run_rev", 32'h1, drive_cmd.run_rev);
    c.fwd = 1'b0;
    put(20);
    chk("run_rev", 32'h1, drive_cmd.run_rev);
    c.rev = 1'b0;
    put(20);
    chk("run_rev", 32'h0, drive_cmd.run_rev);
    c.rev = 1'b1;
    put(20);
    chk("run_rev", 32'h0, drive_cmd.run_rev);
    c.fwd = 1'b1;
    put(20);
    chk("run_rev", 32'h1, drive_cmd.run_rev);
    c.fwd = 1'b0;
    c.rev = 1'b0;
    put(20);
    chk("run_rev", 32'h0, drive_cmd.run_rev);
    c.sel = 3'h7;
    put(20);
    chk("setpoint", 32'h00c8, setpoint);
    wr(`RDC_ADR_CTRL, 32'had);
    hold(5);
    chk("setpoint", 32'h01f4, setpoint);
    $display("test reverse and sections done");
    // pulse signalling, positive then negative setpoint
    c.sel = 3'h1;
    wr(`RDC_ADR_CTRL, 32'h8b);
    put(20);
    blip(1'b0, 10);
    chk("run_fwd", 32'h0, drive_cmd.run_fwd);
    blip(1'b0, 40);
    chk("run_fwd", 32'h1, drive_cmd.run_fwd);
    blip(1'b1, 10);
    chk("run_fwd", 32'h1, drive_cmd.run_fwd);
    blip(1'b1, 40);
    chk("run_fwd", 32'h0, drive_cmd.run_fwd);
    wr(`RDC_ADR_CTRL, 32'h8f);
    c.sel = 3'h2;
    put(20);
    blip(1'b0, 40);
    chk("run_rev", 32'h1, drive_cmd.run_rev);
    chk("run_fwd", 32'h0, drive_cmd.run_fwd);
    blip(1'b1, 40);
    chk("run_rev", 32'h0, drive_cmd.run_rev);
    $display("test pulse done");
    // panel setpoint and panel run in local mode
    wr(`RDC_ADR_SETP, 32'h0032);
    rd(`RDC_ADR_SETP, 32'h0032);
    wr(`RDC_ADR_CTRL, 32'hc0);
    hold(5);
    chk("setpoint", 32'h0032, setpoint);
    chk("remote", 32'h0, drive_cmd.remote);
    chk("run_fwd", 32'h1, drive_cmd.run_fwd);
    $display("test panel done");
    // external faults and reset
    c.ext_fault1 = 1'b1;
    put(20);
    chk("estop", 32'h1, drive_cmd.estop);
    chk("contactor_open", 32'h1, drive_cmd.contactor_open);
    c.ext_fault1 = 1'b0;
    put(20);
    chk("contactor_open", 32'h0, drive_cmd.contactor_open);
    chk("estop", 32'h0, drive_cmd.estop);
    @(posedge clk);
    estop_button <= 1'b1;
    hold(5);
    chk("estop", 32'h1, drive_cmd.estop);
    r0 = resets;
    c.ext_reset = 1'b1;
    put(20);
    c.ext_reset = 1'b0;
    put(20);
    chk("fault_reset", r0 + 1, resets);
    wr(`RDC_ADR_CMD, 32'h1);
    hold(3);
    chk("fault_reset", r0 + 2, resets);
    $display("test faults done");
    finish_test();
  end
endmodule
